// ---- design/nvmpac_ctrl.sv ----
/*
  nvm access control: data eeprom latch/program sequencer with its
  cell array, flash control register with key unlock, protection
  gating, power-mode handling and serial programming entry detect.
  assumes the cpu bus strobes are synchronous to sys_clk and that the
  programming pins and external reset pin are asynchronous.
*/

module nvmpac_ctrl #(
  parameter int PROG_CYCLES = nvmpac_pkg::PROG_CYCLES,
  parameter int FLASH_AW = 13,
  parameter logic [12:0] SECTOR0_END = 13'h0fff
) (
  // clock, reset, enable
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // eeprom area on the cpu data bus
  input wire nvmpac_pkg::nvmpac_ee_req_t ee_req,
  output nvmpac_pkg::nvmpac_ee_rsp_t ee_rsp,
  // power modes
  input wire logic wait_req,
  input wire logic halt_req,
  output logic ee_idle,
  // option bits and tool access
  input wire logic readout_protect_option,
  input wire logic write_protect_option,
  input wire logic tool_access,
  input wire logic inapplication_programming,
  output logic mass_erase_busy,
  // flash write / erase request
  input wire logic flash_wr_req,
  input wire logic [FLASH_AW-1:0] flash_wr_addr,
  output logic flash_wr_grant,
  output logic flash_wr_refuse,
  // serial programming pins
  input wire logic ext_reset_pin_n,
  input wire logic serial_prog_clock_pin,
  input wire logic serial_prog_data_pin,
  output logic serial_prog_clock_oe,
  output logic serial_prog_clock_pullup,
  output logic sysmem_vector,
  output logic force_rc_osc
);

  // ************************************************
  // declarations
  // ************************************************
  logic [7:0] cells [nvmpac_pkg::EE_BYTES];  // eeprom array
  logic [7:0] latch_data [nvmpac_pkg::LATCH_COUNT];  // data latches
  logic [nvmpac_pkg::LATCH_COUNT-1:0] latch_used;  // latch holds data
  logic [7:0] row_base;  // row from last latched write
  logic latch_mode_bit;  // eeprom write mode
  logic program_go_bit;  // eeprom programming active
  logic [2:0] flash_ctrl;  // opt, lat, pgm of flash register
  logic [1:0] key_stage;  // 0 locked, 1 first key seen, 2 unlocked
  logic pin_dir;  // application wants clock pin as output
  nvmpac_pkg::nvmpac_ee_state_t ee_state;
  logic [31:0] prog_cnt;  // programming cycle timer
  logic [7:0] erase_idx;  // mass erase pointer
  logic wait_pend;  // wait request seen, idle after cycle
  logic halted;  // stopped by halt
  logic rp_prev;  // readout option last cycle
  logic [2:0] sync_rst;  // external reset pin synchroniser
  logic [2:0] sync_clk;  // serial clock pin synchroniser
  logic [2:0] sync_dat;  // serial data pin synchroniser
  logic pin_rst_n;  // filtered external reset
  logic pin_clk;  // filtered serial clock
  logic pin_dat;  // filtered serial data
  logic [5:0] pulse_cnt;  // clock pulses seen while reset low
  logic [7:0] next_latch;  // and-merged latch value
  logic ee_wr_hit;  // accepted eeprom write
  logic prog_done;  // cycle timer expired
  logic ee_rd_block;  // readout protection blocks this read
  logic wr_ee_ctrl;
  logic wr_flash_ctrl;
  logic sw_clear_go;  // software drops go mid-cycle

  // strobe decode
  assign wr_ee_ctrl = reg_wr && (reg_addr == nvmpac_pkg::EE_CTRL_OFS);
  assign wr_flash_ctrl = reg_wr && (reg_addr == nvmpac_pkg::FLASH_CTRL_OFS);
  assign sw_clear_go = wr_ee_ctrl && !reg_wdata[nvmpac_pkg::PGM_POS] && ee_state == nvmpac_pkg::EE_PROG;
  assign prog_done = (ee_state == nvmpac_pkg::EE_PROG) && (prog_cnt == 32'(PROG_CYCLES - 1));
  assign ee_wr_hit = ee_req.wr && latch_mode_bit && !program_go_bit && !ee_rd_block;
  assign ee_rd_block = readout_protect_option && tool_access;
  assign next_latch = latch_used[ee_req.addr[nvmpac_pkg::COL_BITS-1:0]]
    ? (latch_data[ee_req.addr[nvmpac_pkg::COL_BITS-1:0]] & ee_req.wdata) : ee_req.wdata;

  // ************************************************
  // pin synchronisers, three stages, agree on last two
  // ************************************************
  // async pins reach the filtered level only when stages two and three agree
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync_rst <= 3'h7;
      sync_clk <= 3'h7;
      sync_dat <= 3'h7;
      pin_rst_n <= 1'b1;
      pin_clk <= 1'b1;
      pin_dat <= 1'b1;
    end else if (clk_en) begin
      sync_rst <= {sync_rst[1:0], ext_reset_pin_n};
      sync_clk <= {sync_clk[1:0], serial_prog_clock_pin};
      sync_dat <= {sync_dat[1:0], serial_prog_data_pin};
      if (sync_rst[1] == sync_rst[2]) begin
        pin_rst_n <= sync_rst[2];
      end
      if (sync_clk[1] == sync_clk[2]) begin
        pin_clk <= sync_clk[2];
      end
      if (sync_dat[1] == sync_dat[2]) begin
        pin_dat <= sync_dat[2];
      end
    end
  end

  // ************************************************
  // programming entry detect
  // ************************************************
  // pulses on the clock pin are counted only while the tool holds reset
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pulse_cnt <= 6'h00;
      sysmem_vector <= 1'b0;
      force_rc_osc <= 1'b0;
    end else if (clk_en) begin
      if (!pin_rst_n) begin
        if (!pin_clk && sync_clk[2] && sync_clk[1] && pulse_cnt != 6'h3f) begin
          pulse_cnt <= pulse_cnt + 6'h01;
        end
      end else if (!sync_rst[2] || !sync_rst[1]) begin
        pulse_cnt <= pulse_cnt;
      end else if (pulse_cnt != 6'h00) begin
        sysmem_vector <= (pulse_cnt == nvmpac_pkg::ENTRY_PULSES_RC)
          || (pulse_cnt == nvmpac_pkg::ENTRY_PULSES_EXT);
        force_rc_osc <= (pulse_cnt == nvmpac_pkg::ENTRY_PULSES_RC);
        pulse_cnt <= 6'h00;
      end
    end
  end

  // ************************************************
  // serial clock pin direction
  // ************************************************
  // reset restores input
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      pin_dir <= 1'b0;
    end else if (clk_en) begin
      if (!pin_rst_n) begin
        pin_dir <= 1'b0;  // external reset also releases the pin
      end else if (reg_wr && reg_addr == nvmpac_pkg::PIN_CTRL_OFS) begin
        pin_dir <= reg_wdata[0];
      end
    end
  end
  assign serial_prog_clock_oe = pin_dir;
  assign serial_prog_clock_pullup = !pin_dir;

  // ************************************************
  // eeprom control bits
  // ************************************************
  // hardware clears win over software writes in the same cycle
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_mode_bit <= nvmpac_pkg::EE_CTRL_RST[nvmpac_pkg::LAT_POS];
      program_go_bit <= nvmpac_pkg::EE_CTRL_RST[nvmpac_pkg::PGM_POS];
    end else if (clk_en) begin
      if (prog_done || (halt_req && ee_state == nvmpac_pkg::EE_PROG)) begin
        latch_mode_bit <= 1'b0;
        program_go_bit <= 1'b0;
      end else if (wr_ee_ctrl) begin
        if (reg_wdata[nvmpac_pkg::LAT_POS] || !program_go_bit) begin
          latch_mode_bit <= reg_wdata[nvmpac_pkg::LAT_POS];
        end
        // go only starts from write mode
        if (!reg_wdata[nvmpac_pkg::PGM_POS] || latch_mode_bit) begin
          program_go_bit <= reg_wdata[nvmpac_pkg::PGM_POS];
        end
      end
    end
  end

  // ************************************************
  // data latches and row capture
  // ************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      latch_used <= '0;
      row_base <= 8'h00;
      for (int i = 0; i < nvmpac_pkg::LATCH_COUNT; i++) begin
        latch_data[i] <= 8'hff;
      end
    end else if (clk_en) begin
      if (prog_done || (halt_req && ee_state == nvmpac_pkg::EE_PROG) || (wr_ee_ctrl && latch_mode_bit
          && !program_go_bit && !reg_wdata[nvmpac_pkg::LAT_POS])) begin
        latch_used <= '0;
      end else if (ee_wr_hit) begin
        latch_data[ee_req.addr[nvmpac_pkg::COL_BITS-1:0]] <= next_latch;
        latch_used[ee_req.addr[nvmpac_pkg::COL_BITS-1:0]] <= 1'b1;
        row_base <= {ee_req.addr[7:nvmpac_pkg::COL_BITS], {nvmpac_pkg::COL_BITS{1'b0}}};
      end
    end
  end

  // ************************************************
  // eeprom sequencer
  // ************************************************
  // a reset mid-cycle drops the timer, so cells keep whatever state they had
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ee_state <= nvmpac_pkg::EE_IDLE;
      prog_cnt <= 32'h0;
      erase_idx <= 8'h00;
      wait_pend <= 1'b0;
      halted <= 1'b0;
      rp_prev <= 1'b0;
    end else if (clk_en) begin
      rp_prev <= readout_protect_option;
      wait_pend <= wait_req ? 1'b1 : (ee_state == nvmpac_pkg::EE_IDLE ? 1'b0 : wait_pend);
      halted <= halt_req;
      unique case (ee_state)
        nvmpac_pkg::EE_IDLE: begin
          prog_cnt <= 32'h0;
          if (rp_prev && !readout_protect_option) begin
            ee_state <= nvmpac_pkg::EE_ERASE;
            erase_idx <= 8'h00;
          end else if (program_go_bit && !halt_req && !wait_req) begin
            ee_state <= nvmpac_pkg::EE_PROG;
          end
        end
        nvmpac_pkg::EE_PROG: begin
          if (halt_req || sw_clear_go) begin
            ee_state <= nvmpac_pkg::EE_IDLE;
          end else if (prog_done) begin
            ee_state <= nvmpac_pkg::EE_IDLE;
          end else begin
            prog_cnt <= prog_cnt + 32'h1;
          end
        end
        nvmpac_pkg::EE_ERASE: begin
          erase_idx <= erase_idx + 8'h01;
          if (erase_idx == 8'hff) begin
            ee_state <= nvmpac_pkg::EE_IDLE;
          end
        end
      endcase
    end
  end

  // ************************************************
  // eeprom cell array
  // ************************************************
  // array is not reset: real cells keep contents across resets
  always_ff @(posedge sys_clk) begin
    if (clk_en) begin
      if (ee_state == nvmpac_pkg::EE_ERASE) begin
        cells[erase_idx] <= 8'hff;
      end else if (prog_done) begin
        for (int i = 0; i < nvmpac_pkg::LATCH_COUNT; i++) begin
          if (latch_used[i]) begin
            cells[row_base | 8'(i)] <= latch_data[i];
          end
        end
      end
    end
  end

  // ************************************************
  // eeprom read path
  // ************************************************
  // latches never read back
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      ee_rsp <= '0;
    end else if (clk_en) begin
      ee_rsp.oe <= 1'b0;
      ee_rsp.rdata <= 8'h00;
      if (ee_req.rd && !latch_mode_bit && !ee_rd_block && ee_state != nvmpac_pkg::EE_ERASE) begin
        ee_rsp.oe <= 1'b1;
        ee_rsp.rdata <= cells[ee_req.addr];
      end
    end
  end

  // ************************************************
  // flash control register and key unlock
  // ************************************************
  // any wrong byte while locked restarts the key sequence
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      key_stage <= 2'h0;
      flash_ctrl <= nvmpac_pkg::FLASH_CTRL_RST[2:0];
    end else if (clk_en && wr_flash_ctrl) begin
      unique case (key_stage)
        2'h0: key_stage <= (reg_wdata == nvmpac_pkg::KEY_FIRST) ? 2'h1 : 2'h0;
        2'h1: key_stage <= (reg_wdata == nvmpac_pkg::KEY_SECOND) ? 2'h2 : 2'h0;
        2'h2: flash_ctrl <= reg_wdata[2:0];
        default: key_stage <= 2'h0;
      endcase
    end
  end

  // ************************************************
  // flash write / erase gate
  // ************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      flash_wr_grant <= 1'b0;
      flash_wr_refuse <= 1'b0;
    end else if (clk_en) begin
      flash_wr_grant <= 1'b0;
      flash_wr_refuse <= 1'b0;
      if (flash_wr_req) begin
        if (write_protect_option || key_stage != 2'h2 || !flash_ctrl[nvmpac_pkg::PGM_POS]
            || (inapplication_programming && flash_wr_addr <= SECTOR0_END[FLASH_AW-1:0])
            || (readout_protect_option && tool_access)) begin
          flash_wr_refuse <= 1'b1;
        end else begin
          flash_wr_grant <= 1'b1;
        end
      end
    end
  end

  // ************************************************
  // register read port
  // ************************************************
  always_ff @(posedge sys_clk or negedge reset_n) begin
    if (!reset_n) begin
      reg_rdata <= 8'h00;
    end else if (clk_en) begin
      reg_rdata <= 8'h00;
      if (reg_rd) begin
        unique case (reg_addr)
          nvmpac_pkg::EE_CTRL_OFS: reg_rdata <= {6'h00, latch_mode_bit, program_go_bit};
          nvmpac_pkg::FLASH_CTRL_OFS: reg_rdata <= {5'h00, flash_ctrl};
          nvmpac_pkg::STATUS_OFS: reg_rdata <= {pin_dat, force_rc_osc, sysmem_vector,
            key_stage == 2'h2, halted, wait_pend, mass_erase_busy, ee_idle};
          nvmpac_pkg::PIN_CTRL_OFS: reg_rdata <= {7'h00, pin_dir};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // idle once no cycle runs and a wait or halt is pending
  assign ee_idle = (ee_state == nvmpac_pkg::EE_IDLE) && (wait_pend || halted || halt_req);
  assign mass_erase_busy = (ee_state == nvmpac_pkg::EE_ERASE);

endmodule

// ---- design/nvmpac_pkg.sv ----
/*
  shared constants and carriers for the nvm access control block:
  register offsets, field positions, reset values, keys and timing.
  assumes a 40 mhz system clock and an 8-bit cpu data bus.
*/
package nvmpac_pkg;

  // ************************************************
  // register map
  // ************************************************
  localparam logic [7:0] EE_CTRL_OFS = 8'h30;  // eeprom control register
  localparam logic [7:0] FLASH_CTRL_OFS = 8'h29;  // flash control register
  localparam logic [7:0] STATUS_OFS = 8'h2a;  // block status, read only
  localparam logic [7:0] PIN_CTRL_OFS = 8'h2b;  // serial clock pin direction

  // ************************************************
  // field positions and reset values
  // ************************************************
  localparam int PGM_POS = 0;  // program-go bit
  localparam int LAT_POS = 1;  // latch-mode bit
  localparam int OPT_POS = 2;  // option select (flash only)
  localparam logic [7:0] EE_CTRL_RST = 8'h00;
  localparam logic [7:0] FLASH_CTRL_RST = 8'h00;

  // unlock keys for the flash control register
  localparam logic [7:0] KEY_FIRST = 8'h56;
  localparam logic [7:0] KEY_SECOND = 8'hae;

  // ************************************************
  // geometry
  // ************************************************
  localparam int LATCH_COUNT = 32;  // data latches per row
  localparam int COL_BITS = 5;  // low address bits select a latch
  localparam int EE_BYTES = 256;  // eeprom size

  // ************************************************
  // programming entry pulse counts
  // ************************************************
  localparam logic [5:0] ENTRY_PULSES_RC = 6'h26;  // 38 pulses, forced rc
  localparam logic [5:0] ENTRY_PULSES_EXT = 6'h23;  // 35 pulses, tool clock

  // ************************************************
  // timing
  // ************************************************
  localparam longint CLK_HZ = 40000000;
  localparam longint PROG_TIME_US = 5000;  // cell program time, plain default
  localparam int PROG_CYCLES = int'((PROG_TIME_US * CLK_HZ) / 1000000);

  // ************************************************
  // carriers
  // ************************************************
  typedef struct packed {
    logic [7:0] addr;  // byte inside the eeprom area
    logic [7:0] wdata;  // write data
    logic wr;  // one-cycle write strobe
    logic rd;  // one-cycle read strobe
  } nvmpac_ee_req_t;

  typedef struct packed {
    logic [7:0] rdata;  // read data, valid one cycle after rd
    logic oe;  // high when eeprom drives the data bus
  } nvmpac_ee_rsp_t;

  // eeprom sequencer states
  typedef enum logic [1:0] {
    EE_IDLE,
    EE_PROG,
    EE_ERASE
  } nvmpac_ee_state_t;

endpackage

// ---- verif/nvmpac_cpu_model.sv ----
/*
  cpu model driving the register port and the eeprom area.
  assumes strobes sampled on the rising edge, answers one cycle later.
*/
module nvmpac_cpu_model (
  // clock
  input wire logic sys_clk,
  // register port
  output logic [7:0] reg_addr,
  output logic [7:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [7:0] reg_rdata,
  // eeprom area
  output nvmpac_pkg::nvmpac_ee_req_t ee_req,
  input wire nvmpac_pkg::nvmpac_ee_rsp_t ee_rsp
);
  timeunit 1ns;
  timeprecision 1ps;

  // idle bus at time zero
  initial begin
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    ee_req = '0;
  end

  // released lines show inverted values, never stale ones
  task automatic reg_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {a, d, 1'b1};
    @(posedge sys_clk);
    {reg_addr, reg_wdata, reg_wr} <= {~a, ~d, 1'b0};
  endtask

  task automatic reg_read(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {a, 1'b1};
    @(posedge sys_clk);
    {reg_addr, reg_rd} <= {~a, 1'b0};
    #1 d = reg_rdata;
  endtask

  // row kept by caller, low five bits vary
  task automatic ee_write(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    ee_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge sys_clk);
    ee_req <= '{addr: ~a, wdata: ~d, wr: 1'b0, rd: 1'b0};
  endtask

  task automatic ee_read(input logic [7:0] a, output logic [7:0] d, output logic o);
    @(posedge sys_clk);
    ee_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge sys_clk);
    ee_req <= '{addr: ~a, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
    #1 d = ee_rsp.rdata;
    o = ee_rsp.oe;
  endtask
endmodule

// ---- verif/nvmpac_ctrl_sva.sv ----
/*
  checker for the nvm access control block, ports only.
  assumes one clock domain and the async active-low reset.
*/
module nvmpac_ctrl_sva #(
  parameter logic [12:0] SECTOR0_END = 13'h0fff
) (
  // clock and reset
  input wire logic sys_clk,
  input wire logic reset_n,
  // register and eeprom ports
  input wire logic [7:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire nvmpac_pkg::nvmpac_ee_req_t ee_req,
  input wire nvmpac_pkg::nvmpac_ee_rsp_t ee_rsp,
  // power, options, flash gate, pins
  input wire logic halt_req,
  input wire logic ee_idle,
  input wire logic readout_protect_option,
  input wire logic write_protect_option,
  input wire logic tool_access,
  input wire logic inapplication_programming,
  input wire logic mass_erase_busy,
  input wire logic flash_wr_req,
  input wire logic [12:0] flash_wr_addr,
  input wire logic flash_wr_grant,
  input wire logic flash_wr_refuse,
  input wire logic serial_prog_clock_oe,
  input wire logic serial_prog_clock_pullup,
  input wire logic sysmem_vector,
  input wire logic force_rc_osc
);
  // ************************************************
  // properties
  // ************************************************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!reset_n);

  // tool read of a protected part
  sequence s_prot_read;
    readout_protect_option && tool_access && ee_req.rd;
  endsequence

  AST_RO_BLOCK: assert property (s_prot_read |=> !ee_rsp.oe) else $error("protected read drove bus");
  AST_ERASE_START: assert property ($fell(readout_protect_option) |-> ##[1:4] mass_erase_busy) else $error("no erase");
  AST_ERASE_NO_RD: assert property (mass_erase_busy && ee_req.rd |=> !ee_rsp.oe) else $error("read in erase");
  AST_OE_CAUSE: assert property (ee_rsp.oe |-> $past(ee_req.rd)) else $error("bus driven without read");
  AST_CTRL_HI_ZERO: assert property (reg_rd && reg_addr == nvmpac_pkg::EE_CTRL_OFS |=>
    reg_rdata[7:2] == 6'h00) else $error("reserved bits not zero");
  AST_WP_REFUSE: assert property (flash_wr_req && write_protect_option |=> flash_wr_refuse && !flash_wr_grant)
    else $error("protected flash granted");
  AST_SEC0_REFUSE: assert property (flash_wr_req && inapplication_programming && flash_wr_addr <= SECTOR0_END
    |=> flash_wr_refuse) else $error("sector 0 granted");
  AST_ONE_ANSWER: assert property (flash_wr_req |=> flash_wr_grant != flash_wr_refuse) else $error("bad answer");
  AST_PIN_PULLUP: assert property (serial_prog_clock_pullup == !serial_prog_clock_oe
    && (!$rose(reset_n) || !serial_prog_clock_oe)) else $error("pull-up wrong");
  AST_RC_ONLY_ENTRY: assert property (force_rc_osc |-> sysmem_vector) else $error("rc without entry");
  AST_HALT_IDLE: assert property ($rose(halt_req) |-> ##[0:3] ee_idle) else $error("halt not idle");
endmodule

// ---- verif/nvmpac_ctrl_tb.sv ----
/*
  self-checking bench for the nvm access control block.
  assumes a short program time parameter and erased cells via option.
*/
module nvmpac_ctrl_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wait_req = 1'b0, halt_req = 1'b0, tool_access = 1'b1, inapplication_programming = 1'b0;
  logic readout_protect_option = 1'b1, write_protect_option = 1'b0, flash_wr_req = 1'b0;
  logic ext_reset_pin_n = 1'b1, serial_prog_clock_pin = 1'b1;
  logic [12:0] flash_wr_addr = 13'h1000;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic reg_wr, reg_rd, ee_idle, mass_erase_busy, flash_wr_grant, flash_wr_refuse, oe;
  logic serial_prog_clock_oe, serial_prog_clock_pullup, sysmem_vector, force_rc_osc;
  nvmpac_pkg::nvmpac_ee_req_t ee_req;
  nvmpac_pkg::nvmpac_ee_rsp_t ee_rsp;
  int fail_count = 0;
  int num_checks = 0;

  // 40 mhz clock
  always #12.5 sys_clk = ~sys_clk;

  nvmpac_cpu_model cpu (.sys_clk(sys_clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ee_req(ee_req), .ee_rsp(ee_rsp));

  // short program time keeps the run brief
  nvmpac_ctrl #(.PROG_CYCLES(8)) dut (.sys_clk(sys_clk), .reset_n(reset_n), .clk_en(1'b1),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .ee_req(ee_req), .ee_rsp(ee_rsp), .wait_req(wait_req), .halt_req(halt_req), .ee_idle(ee_idle),
    .readout_protect_option(readout_protect_option), .write_protect_option(write_protect_option),
    .tool_access(tool_access), .inapplication_programming(inapplication_programming),
    .mass_erase_busy(mass_erase_busy), .flash_wr_req(flash_wr_req), .flash_wr_addr(flash_wr_addr),
    .flash_wr_grant(flash_wr_grant), .flash_wr_refuse(flash_wr_refuse), .ext_reset_pin_n(ext_reset_pin_n),
    .serial_prog_clock_pin(serial_prog_clock_pin), .serial_prog_data_pin(1'b1),
    .serial_prog_clock_oe(serial_prog_clock_oe), .serial_prog_clock_pullup(serial_prog_clock_pullup),
    .sysmem_vector(sysmem_vector), .force_rc_osc(force_rc_osc));

  // ************************************************
  // helpers
  // ************************************************
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic rr(input logic [7:0] a, input logic [7:0] exp);
    cpu.reg_read(a, d);
    chk(d, exp);
  endtask

  // bus undriven reads only compare the enable
  task automatic er(input logic [7:0] a, input logic [7:0] exp, input logic exp_oe);
    cpu.ee_read(a, d, oe);
    chk({7'h00, oe}, {7'h00, exp_oe});
    if (exp_oe) chk(d, exp);
  endtask

  // poll control until the cycle ends; bounded
  task automatic done_wait;
    for (int i = 0; i < 40; i++) begin
      cpu.reg_read(nvmpac_pkg::EE_CTRL_OFS, d);
      if (d !== 8'h03) break;
    end
    chk(d, 8'h00);
  endtask

  task automatic fl(input logic g);
    @(posedge sys_clk) flash_wr_req <= 1'b1;
    @(posedge sys_clk) flash_wr_req <= 1'b0;
    #1 chk({6'h00, flash_wr_grant, flash_wr_refuse}, {6'h00, g, ~g});
  endtask

  // entry pulses while the reset pin is low
  task automatic entry(input int n, input logic [1:0] exp);
    @(posedge sys_clk) ext_reset_pin_n <= 1'b0;
    repeat (n) begin
      repeat (3) @(posedge sys_clk);
      serial_prog_clock_pin <= 1'b0;
      repeat (3) @(posedge sys_clk);
      serial_prog_clock_pin <= 1'b1;
    end
    #1 chk({6'h00, serial_prog_clock_oe, serial_prog_clock_pullup}, 8'h01);
    @(posedge sys_clk) ext_reset_pin_n <= 1'b1;
    repeat (10) @(posedge sys_clk);
    #1 chk({6'h00, sysmem_vector, force_rc_osc}, {6'h00, exp});
  endtask

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    rr(8'h30, nvmpac_pkg::EE_CTRL_RST);
    rr(8'h29, nvmpac_pkg::FLASH_CTRL_RST);
    rr(8'h3f, 8'h00);
    er(8'h10, 8'h00, 1'b0);
    fl(1'b0);
    @(posedge sys_clk) {readout_protect_option, tool_access} <= 2'b00;
    er(8'h10, 8'h00, 1'b0);
    for (int i = 0; i < 400 && mass_erase_busy !== 1'b0; i++) @(posedge sys_clk);
    #1 chk({7'h00, mass_erase_busy}, 8'h00);
    er(8'h10, 8'hff, 1'b1);
    cpu.ee_write(8'h45, 8'h00);
    er(8'h45, 8'hff, 1'b1);
    cpu.reg_write(8'h30, 8'h02);
    rr(8'h30, 8'h02);
    cpu.ee_write(8'h45, 8'h5a);
    cpu.ee_write(8'h45, 8'hf0);
    cpu.ee_write(8'h5f, 8'h12);
    er(8'h45, 8'h00, 1'b0);
    cpu.reg_write(8'h30, 8'h03);
    cpu.reg_write(8'h30, 8'h01);
    rr(8'h30, 8'h03);
    done_wait();
    er(8'h45, 8'h50, 1'b1);
    er(8'h5f, 8'h12, 1'b1);
    er(8'h46, 8'hff, 1'b1);
    cpu.reg_write(8'h30, 8'h02);
    cpu.ee_write(8'h60, 8'h00);
    cpu.reg_write(8'h30, 8'h00);
    cpu.reg_write(8'h30, 8'h02);
    cpu.reg_write(8'h30, 8'h03);
    done_wait();
    er(8'h60, 8'hff, 1'b1);
    cpu.reg_write(8'h30, 8'h02);
    cpu.ee_write(8'ha0, 8'h00);
    cpu.reg_write(8'h30, 8'h03);
    @(posedge sys_clk) wait_req <= 1'b1;
    #1 chk({7'h00, ee_idle}, 8'h00);
    done_wait();
    chk({7'h00, ee_idle}, 8'h01);
    @(posedge sys_clk) wait_req <= 1'b0;
    repeat (2) @(posedge sys_clk);
    er(8'ha0, 8'h00, 1'b1);
    cpu.reg_write(8'h30, 8'h02);
    cpu.ee_write(8'h80, 8'h00);
    cpu.reg_write(8'h30, 8'h03);
    @(posedge sys_clk) halt_req <= 1'b1;
    repeat (3) @(posedge sys_clk);
    #1 chk({7'h00, ee_idle}, 8'h01);
    rr(8'h30, 8'h00);
    @(posedge sys_clk) halt_req <= 1'b0;
    cpu.reg_write(8'h30, 8'h02);
    cpu.reg_write(8'h30, 8'h03);
    done_wait();
    er(8'h80, 8'hff, 1'b1);
    fl(1'b0);
    cpu.reg_write(8'h29, nvmpac_pkg::KEY_FIRST);
    cpu.reg_write(8'h29, nvmpac_pkg::KEY_SECOND);
    cpu.reg_write(8'h29, 8'h01);
    rr(8'h29, 8'h01);
    fl(1'b1);
    @(posedge sys_clk) {inapplication_programming, flash_wr_addr} <= {1'b1, 13'h0fff};
    fl(1'b0);
    @(posedge sys_clk) flash_wr_addr <= 13'h1000;
    fl(1'b1);
    @(posedge sys_clk) {inapplication_programming, write_protect_option} <= 2'b01;
    fl(1'b0);
    cpu.reg_write(8'h2b, 8'h01);
    entry(38, 2'b11);
    entry(35, 2'b10);
    rr(8'h2a, 8'hb0);
    rr(8'h2b, 8'h00);
    cpu.reg_write(8'h30, 8'h02);
    cpu.reg_write(8'h30, 8'h03);
    @(posedge sys_clk) reset_n <= 1'b0;
    @(posedge sys_clk) reset_n <= 1'b1;
    rr(8'h30, 8'h00);
    give_verdict();
  end

  // hang guard
  initial begin
    repeat (20000) @(posedge sys_clk);
    fail_count++;
    give_verdict();
  end
endmodule

bind nvmpac_ctrl nvmpac_ctrl_sva #(.SECTOR0_END(SECTOR0_END)) chk_i (.sys_clk(sys_clk), .reset_n(reset_n),
  .reg_addr(reg_addr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .ee_req(ee_req), .ee_rsp(ee_rsp),
  .halt_req(halt_req), .ee_idle(ee_idle), .readout_protect_option(readout_protect_option),
  .write_protect_option(write_protect_option), .tool_access(tool_access),
  .inapplication_programming(inapplication_programming), .mass_erase_busy(mass_erase_busy),
  .flash_wr_req(flash_wr_req), .flash_wr_addr(flash_wr_addr), .flash_wr_grant(flash_wr_grant),
  .flash_wr_refuse(flash_wr_refuse), .serial_prog_clock_oe(serial_prog_clock_oe),
  .serial_prog_clock_pullup(serial_prog_clock_pullup), .sysmem_vector(sysmem_vector), .force_rc_osc(force_rc_osc));
